// ---- bench/ext_irq_properties.sv ----
// Port assertions for the external edge interrupt block
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module ext_irq_properties #(
  parameter int NUM_SRC = 5            // Number of sources
) (
  input wire logic        pclk,           // Clock
  input wire logic        presetn,        // Reset, low
  input wire logic        psel,           // Select
  input wire logic        penable,        // Access phase
  input wire logic        pwrite,         // Direction
  input wire logic [11:0] paddr,          // Byte address
  input wire logic [31:0] pwdata,         // Write data
  input wire logic [31:0] prdata,         // Read data
  input wire logic        pready,         // Ready
  input wire logic        pslverr,        // Error
  input wire logic [4:0]  ext_int_pin,    // Pins
  input wire logic        service_ack,    // Core accept
  input wire logic        cpu_irq_req,    // Request
  input wire logic [15:0] cpu_irq_vector, // Vector
  input wire logic        irq             // Level interrupt
);
  wire acc = psel && penable;             // Access phase seen

  // Index decode of every mapped register
  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && a[11:10] == 2'h0 && a[9:2] inside {
      `IDX_TIMER_EXT_INT_CONTROL, `IDX_EDGE_SELECT_LOW,
      `IDX_INTERRUPT_ENABLE_MAIN, `IDX_AUX_INTERRUPT_REQUESTS,
      `IDX_EDGE_SELECT_HIGH, `IDX_EVENT_STATUS, `IDX_EVENT_MASK,
      `IDX_SERVICE};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One wait state, then a single ready pulse
  property p_ready_next; acc && !pready |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  // Error only and always on an unmapped index
  property p_err_unmapped;
    acc && pready && !mapped(paddr) |-> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no err");
  property p_err_mapped; acc && pready && mapped(paddr) |-> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("false err");
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("err data");
  property p_data_top; pready |-> prdata[31:24] == 8'h00; endproperty
  a_data_top: assert property (p_data_top) else $error("top bits set");
  // Only the five fixed vectors may be offered
  property p_vec_fixed;
    cpu_irq_req |-> cpu_irq_vector inside {`VEC_0, `VEC_1, `VEC_2,
      `VEC_3, `VEC_4};
  endproperty
  a_vec_fixed: assert property (p_vec_fixed)
    else $error("bad vector");
  // A pending request stays until written or serviced
  property p_req_holds;
    (!(acc && pwrite) && !service_ack)[*4] ##0 cpu_irq_req |=> cpu_irq_req;
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("req lost");

  c_req: cover property ($rose(cpu_irq_req));
  c_err: cover property (pslverr);
  c_ack: cover property (service_ack && cpu_irq_req);
  c_irq: cover property ($rose(irq));
endmodule // ext_irq_properties

bind external_edge_interrupts ext_irq_properties #(.NUM_SRC(NUM_SRC)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_int_pin(ext_int_pin),
  .service_ack(service_ack), .cpu_irq_req(cpu_irq_req),
  .cpu_irq_vector(cpu_irq_vector), .irq(irq));

// ---- bench/pin_source.sv ----
// Model of the signal sources that drive the five port pins
`timescale 1ns/1ps
module pin_source (
  input  wire logic       pclk,   // System clock
  input  wire logic       slow,   // Add two cycles of lag
  input  wire logic [4:0] level,  // Wanted pin levels
  output logic      [4:0] pins    // Levels seen at the pins
);
  logic [4:0] stage [2];          // Lag line for a slow source

  ////////////////////////////////////////////////////////////////////////////
  // Pins idle high like pulled-up lines until the first clock edge
  initial pins = 5'h1f;

  // Pins move just after an edge and then stand still
  always @(posedge pclk) begin
    stage[0] <= level;
    stage[1] <= stage[0];
    pins     <= slow ? stage[1] : level;
  end
endmodule // pin_source

// ---- bench/testbench.sv ----
// Self-checking bench for the external edge interrupt block
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module testbench;
  import ext_irq_pkg::*;
  typedef struct {logic [31:0] d; logic c; logic e;} note_type;
  logic        pclk, presetn, psel, penable, pwrite;  // Bus side
  logic        pready, pslverr, service_ack, slow;   // Handshakes
  logic        cpu_irq_req, irq;                     // Requests
  logic [11:0] paddr;                                // Byte address
  logic [31:0] pwdata, prdata;                       // Data
  logic [4:0]  ext_int_pin, lvl, m, e;               // Pin levels
  logic [15:0] cpu_irq_vector;                       // Offered vector
  logic [15:0] vec [5] = '{`VEC_0, `VEC_1, `VEC_2, `VEC_3, `VEC_4};
  note_type    notes[$];                             // Expected answers
  note_type    n;                                    // Oldest note
  int          errors = 0, total_checks = 0, seed = 45;

  external_edge_interrupts #(.NUM_SRC(5)) i_external_edge_interrupts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_int_pin(ext_int_pin),
    .service_ack(service_ack), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_vector(cpu_irq_vector), .irq(irq));
  pin_source i_pin_source (.pclk(pclk), .slow(slow), .level(lvl),
    .pins(ext_int_pin));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(int c);
    repeat (c) @(posedge pclk);
  endtask

  // One bus transfer; the note is queued before the request
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] d, logic c,
                     logic er);
    int k;
    k = 0;
    notes.push_back('{d, c, er});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 40);
    if (k >= 40) check("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] idx, logic [31:0] d);
    apb(1'b1, idx, d, 1'b0, 1'b0);
  endtask
  task automatic rd(logic [7:0] idx, logic [31:0] d);
    apb(1'b0, idx, d, 1'b1, 1'b0);
  endtask

  // Monitor takes the oldest note whenever an answer appears
  always @(posedge pclk)
    if (pready === 1'b1) begin
      if (notes.size() == 0) check("spare answer", 0, 1);
      else begin
        n = notes.pop_front();
        check("pslverr", {31'h0, n.e}, {31'h0, pslverr});
        if (n.c) check("prdata", n.d, prdata);
      end
    end

  // Watchdog: far longer than the whole sequence needs
  initial begin
    #250000;
    errors++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; service_ack = 1'b0; slow = 1'b0;
    lvl = 5'h1f;
    tick(12);
    presetn <= 1'b1;
    rd(`IDX_EDGE_SELECT_LOW, 32'haa);
    rd(`IDX_EDGE_SELECT_HIGH, 32'h02);
    rd(`IDX_INTERRUPT_ENABLE_MAIN, 32'h0);
    rd(`IDX_TIMER_EXT_INT_CONTROL, 32'h0);
    rd(`IDX_AUX_INTERRUPT_REQUESTS, 32'h0);
    apb(1'b0, 8'h00, 32'h0, 1'b1, 1'b1);
    apb(1'b1, 8'h40, 32'hff, 1'b0, 1'b1);
    wr(`IDX_INTERRUPT_ENABLE_MAIN, 32'hf5);
    rd(`IDX_INTERRUPT_ENABLE_MAIN, 32'hf5);
    // Every edge code, random pins falling then rising
    for (int code = 0; code < 4; code++) begin
      slow <= (code == 2);
      wr(`IDX_EDGE_SELECT_LOW, {24'h0, {4{code[1:0]}}});
      wr(`IDX_EDGE_SELECT_HIGH, {24'h0, 6'h3f, code[1:0]});
      rd(`IDX_EDGE_SELECT_HIGH, {30'h0, code[1:0]});
      for (int f = 0; f < 2; f++) begin
        // Rising pass must restore the very pins that fell
        if (f == 0) m = 5'($random(seed));
        lvl <= f ? 5'h1f : ~m;
        tick(10);
        e = (f ? code[0] : code[1]) ? m : 5'h0;
        rd(`IDX_TIMER_EXT_INT_CONTROL, {28'h0, e[1], 1'b0, e[0], 1'b0});
        rd(`IDX_AUX_INTERRUPT_REQUESTS, {29'h0, e[4:2]});
        wr(`IDX_TIMER_EXT_INT_CONTROL, 32'h0);
        wr(`IDX_AUX_INTERRUPT_REQUESTS, 32'h0);
      end
    end
    // Global enable off: status records, flags stay clear
    wr(`IDX_EDGE_SELECT_LOW, 32'haa);
    wr(`IDX_EDGE_SELECT_HIGH, 32'h02);
    wr(`IDX_INTERRUPT_ENABLE_MAIN, 32'h75);
    wr(`IDX_EVENT_STATUS, 32'h1f);
    m = 5'($random(seed)) | 5'h01;
    lvl <= ~m;
    tick(10);
    rd(`IDX_TIMER_EXT_INT_CONTROL, 32'h0);
    rd(`IDX_AUX_INTERRUPT_REQUESTS, 32'h0);
    // Flags are writable by software as well
    wr(`IDX_TIMER_EXT_INT_CONTROL, 32'h0a);
    rd(`IDX_TIMER_EXT_INT_CONTROL, 32'h0a);
    wr(`IDX_TIMER_EXT_INT_CONTROL, 32'h0);
    wr(`IDX_AUX_INTERRUPT_REQUESTS, 32'h07);
    rd(`IDX_AUX_INTERRUPT_REQUESTS, 32'h07);
    wr(`IDX_AUX_INTERRUPT_REQUESTS, 32'h0);
    check("cpu_irq_req", 0, cpu_irq_req);
    rd(`IDX_EVENT_STATUS, {27'h0, m});
    check("irq masked", 0, irq);
    wr(`IDX_EVENT_MASK, 32'h1f);
    tick(4);
    check("irq", 1, irq);
    wr(`IDX_EVENT_STATUS, 32'h1f);
    tick(4);
    check("irq cleared", 0, irq);
    // All five pending, serviced lowest first
    lvl <= 5'h1f;
    tick(10);
    wr(`IDX_INTERRUPT_ENABLE_MAIN, 32'hf5);
    lvl <= 5'h00;
    tick(10);
    rd(`IDX_TIMER_EXT_INT_CONTROL, 32'h0a);
    rd(`IDX_AUX_INTERRUPT_REQUESTS, 32'h07);
    rd(`IDX_SERVICE, 32'h000380);
    for (int k = 0; k < 5; k++) begin
      check("cpu_irq_req", 1, cpu_irq_req);
      check("cpu_irq_vector", vec[k], cpu_irq_vector);
      service_ack <= 1'b1;
      @(posedge pclk);
      service_ack <= 1'b0;
      tick(6);
    end
    check("cpu_irq_req", 0, cpu_irq_req);
    rd(`IDX_TIMER_EXT_INT_CONTROL, 32'h0);
    rd(`IDX_AUX_INTERRUPT_REQUESTS, 32'h0);
    tick(2);
    report_and_stop;
  end
endmodule // testbench

// ---- rtl/ext_irq_params.svh ----
// Register offsets, field positions, reset values and vectors for ext irq
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// Printed offsets (not all multiples of four): kept as indices
`define IDX_TIMER_EXT_INT_CONTROL  8'h88
`define IDX_EDGE_SELECT_LOW        8'h8f
`define IDX_INTERRUPT_ENABLE_MAIN  8'ha8
`define IDX_AUX_INTERRUPT_REQUESTS 8'hc0
`define IDX_EDGE_SELECT_HIGH       8'hc7
// Own registers: status and mask of the level interrupt
`define IDX_EVENT_STATUS           8'hd0
`define IDX_EVENT_MASK             8'hd1
// Vector readback register; writes to it have no effect
`define IDX_SERVICE                8'hd2

// Edge select encodings
`define EDGE_RISE                  2'h1
`define EDGE_FALL                  2'h2
`define EDGE_BOTH                  2'h3
`define EDGE_RESET                 2'h2
`define EDGE_LOW_RESET             8'haa
`define EDGE_HIGH_RESET            8'h02

// Enable register fields
`define GLOBAL_EN_BIT              7
`define EN_BIT_0                   0
`define EN_BIT_1                   2
`define EN_BIT_2                   4
`define EN_BIT_3                   5
`define EN_BIT_4                   6
// Flag fields
`define FLAG_BIT_0                 1
`define FLAG_BIT_1                 3
`define FLAG_BIT_2                 0
`define FLAG_BIT_3                 1
`define FLAG_BIT_4                 2

// Fixed vectors per source
`define VEC_0                      16'h0003
`define VEC_1                      16'h0083
`define VEC_2                      16'h0043
`define VEC_3                      16'h0033
`define VEC_4                      16'h00c3

`endif

// ---- rtl/ext_irq_pkg.sv ----
// Types shared by the external edge interrupt block
package ext_irq_pkg;
  typedef logic [1:0] edge_sel_type;   // Trigger edge selection
  typedef logic [4:0] src_vec_type;    // One bit per source
  typedef enum logic [1:0] {
    apb_idle_st,
    apb_access_st
  } apb_state_type;
endpackage

// ---- rtl/external_edge_interrupts.sv ----
// External edge interrupt controller with APB register access
//
// Overview of operation
// - Five independent pin edge interrupt sources
// - Edge code 01 rise, 10 fall, 11 both
// - Edge fields packed in two edge registers
// - Edge fields reset to falling edge
// - Enabled edge with global enable sets flag
// - Each source has its fixed vector
// - Serviced flag cleared before routine starts
// - Enable bit 7 is global, resets zero
// - Individual enables at bits 6,5,4,2,0
// - Flags 1,0 at control bits 3,1
// - Flags 4,3,2 at aux bits 2,1,0
// - Flag one means request pending
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module external_edge_interrupts #(
  parameter int NUM_SRC = 5                 // Number of sources
) (
  input  wire logic        pclk,            // APB clock, 20 MHz
  input  wire logic        presetn,         // Async reset, active low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB direction
  input  wire logic [11:0] paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic [4:0]  ext_int_pin,     // Port 2 pins 0..4
  input  wire logic        service_ack,     // Core takes top request
  output logic             cpu_irq_req,     // Request to core
  output logic [15:0]      cpu_irq_vector,  // Vector of top request
  output logic             irq              // Level status interrupt
);
  import ext_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////
  edge_sel_type  edge_sel [5];       // Per-source edge selection
  logic [7:0]    enable_main;        // Enable register image
  src_vec_type   request_flag;       // Pending request flags
  src_vec_type   event_status;       // Sticky edge status
  src_vec_type   event_mask;         // Status interrupt mask
  src_vec_type   edge_hit;           // One-cycle edge events
  src_vec_type   src_enable;         // Individual enables in order
  src_vec_type   pending;            // Flags qualified by enables
  src_vec_type   wr_flag_val;        // Flag values from a write
  src_vec_type   wr_flag_sel;        // Which flags a write touches
  src_vec_type   svc_clear;          // Flag cleared by service
  logic [15:0]   top_vector;         // Lookup result
  logic [2:0]    top_src;            // Lookup source number
  logic          top_valid;          // Lookup has request
  apb_state_type apb_state;          // Bus slave state
  logic [7:0]    reg_index;          // Word index of access
  logic          wr_en;              // Write takes effect
  logic          addr_ok;            // Mapped index
  logic          global_en;          // Global enable
  logic          svc_ack_seen;       // Acceptance taken last cycle

  // Stray upper or byte-lane bits map to an unused index, no aliasing
  assign reg_index = (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) ?
                     paddr[9:2] : 8'hff;
  assign wr_en     = psel && penable && pwrite && pready;
  assign global_en = enable_main[`GLOBAL_EN_BIT];
  // Enables gathered in source order
  assign src_enable = {enable_main[`EN_BIT_4], enable_main[`EN_BIT_3],
                       enable_main[`EN_BIT_2], enable_main[`EN_BIT_1],
                       enable_main[`EN_BIT_0]};
  assign pending = global_en ? (request_flag & src_enable) : 5'h00;

  // Mapped index check
  always_comb begin
    case (reg_index)
      `IDX_TIMER_EXT_INT_CONTROL,  `IDX_EDGE_SELECT_LOW,
      `IDX_INTERRUPT_ENABLE_MAIN,  `IDX_AUX_INTERRUPT_REQUESTS,
      `IDX_EDGE_SELECT_HIGH,       `IDX_EVENT_STATUS,
      `IDX_EVENT_MASK,             `IDX_SERVICE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Edge detectors, one per source
  ////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      pin_edge_detect u_det (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin      (ext_int_pin[gi]),
        .edge_sel (edge_sel[gi]),
        .edge_hit (edge_hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Edge select registers
  ////////////////////////////////////////////////////////////////////
  // Reset to falling edge; fields packed two bits each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) begin
        edge_sel[i] <= `EDGE_RESET;
      end
    end else if (wr_en && reg_index == `IDX_EDGE_SELECT_LOW) begin
      edge_sel[0] <= pwdata[1:0];
      edge_sel[1] <= pwdata[3:2];
      edge_sel[2] <= pwdata[5:4];
      edge_sel[3] <= pwdata[7:6];
    end else if (wr_en && reg_index == `IDX_EDGE_SELECT_HIGH) begin
      edge_sel[4] <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enable register
  ////////////////////////////////////////////////////////////////////
  // Timer enables in bits 3 and 1 are stored but unused here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_main <= 8'h00;
    end else if (wr_en && reg_index == `IDX_INTERRUPT_ENABLE_MAIN) begin
      enable_main <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Request flags
  ////////////////////////////////////////////////////////////////////
  // Decode which flags a software write touches
  always_comb begin
    wr_flag_sel = 5'h00;
    wr_flag_val = 5'h00;
    if (wr_en && reg_index == `IDX_TIMER_EXT_INT_CONTROL) begin
      wr_flag_sel[1:0] = 2'h3;
      wr_flag_val[0]   = pwdata[`FLAG_BIT_0];
      wr_flag_val[1]   = pwdata[`FLAG_BIT_1];
    end else if (wr_en && reg_index == `IDX_AUX_INTERRUPT_REQUESTS) begin
      wr_flag_sel[4:2] = 3'h7;
      wr_flag_val[2]   = pwdata[`FLAG_BIT_2];
      wr_flag_val[3]   = pwdata[`FLAG_BIT_3];
      wr_flag_val[4]   = pwdata[`FLAG_BIT_4];
    end
  end

  // Service clears the chosen source's flag on acceptance
  always_comb begin
    svc_clear = 5'h00;
    if (service_ack && top_valid) begin
      svc_clear[top_src] = 1'b1;
    end
  end

  // Edge set wins over software write and service clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_flag <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (edge_hit[i] && src_enable[i] && global_en) begin
          request_flag[i] <= 1'b1;
        end else if (wr_flag_sel[i]) begin
          request_flag[i] <= wr_flag_val[i];
        end else if (svc_clear[i]) begin
          request_flag[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky status, mask and level interrupt
  ////////////////////////////////////////////////////////////////////
  // Status records every qualifying edge; write one clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= 5'h00;
    end else if (wr_en && reg_index == `IDX_EVENT_STATUS) begin
      event_status <= (event_status & ~pwdata[4:0]) | edge_hit;
    end else begin
      event_status <= event_status | edge_hit;
    end
  end

  // Mask of same layout, one enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask <= 5'h00;
    end else if (wr_en && reg_index == `IDX_EVENT_MASK) begin
      event_mask <= pwdata[4:0];
    end
  end

  // Registered level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Core request path
  ////////////////////////////////////////////////////////////////////
  vector_lookup u_vec (
    .pclk    (pclk),
    .presetn (presetn),
    .pending (pending),
    .vector  (top_vector),
    .src_id  (top_src),
    .valid   (top_valid)
  );

  // Request drops as soon as it is taken, to avoid double service;
  // held low one more cycle while the lookup still shows the old source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_req    <= 1'b0;
      cpu_irq_vector <= 16'h0000;
      svc_ack_seen   <= 1'b0;
    end else begin
      svc_ack_seen   <= service_ack;
      cpu_irq_req    <= top_valid && !service_ack &&
                        !svc_ack_seen;
      cpu_irq_vector <= top_vector;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave
  ////////////////////////////////////////////////////////////////////
  // One wait state: ready in second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= apb_idle_st;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
    end else begin
      case (apb_state)
        apb_idle_st: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (psel && penable) begin
            apb_state <= apb_access_st;
            pready    <= 1'b1;
            pslverr   <= !addr_ok;
            prdata    <= 32'h00000000;
            if (!pwrite) begin
              case (reg_index)
                `IDX_TIMER_EXT_INT_CONTROL:
                  prdata[7:0] <= {4'h0, request_flag[1], 1'b0,
                                  request_flag[0], 1'b0};
                `IDX_EDGE_SELECT_LOW:
                  prdata[7:0] <= {edge_sel[3], edge_sel[2],
                                  edge_sel[1], edge_sel[0]};
                `IDX_INTERRUPT_ENABLE_MAIN:
                  prdata[7:0] <= enable_main;
                `IDX_AUX_INTERRUPT_REQUESTS:
                  prdata[7:0] <= {5'h00, request_flag[4:2]};
                `IDX_EDGE_SELECT_HIGH:
                  prdata[7:0] <= {6'h00, edge_sel[4]};
                `IDX_EVENT_STATUS:
                  prdata[7:0] <= {3'h0, event_status};
                `IDX_EVENT_MASK:
                  prdata[7:0] <= {3'h0, event_mask};
                `IDX_SERVICE:
                  prdata[23:0] <= {top_vector, top_valid, 4'h0, top_src};
                default:
                  prdata <= 32'h00000000;
              endcase
            end
          end
        end
        apb_access_st: begin
          apb_state <= apb_idle_st;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default: begin
          apb_state <= apb_idle_st;
          pready    <= 1'b0;
        end
      endcase
    end
  end
endmodule // external_edge_interrupts

// ---- rtl/pin_edge_detect.sv ----
// Synchroniser and edge detector for one external pin
`timescale 1ns/1ps
module pin_edge_detect (
  input  wire logic                       pclk,      // System clock
  input  wire logic                       presetn,   // Async reset, low
  input  wire logic                       pin,       // Raw pin level
  input  wire ext_irq_pkg::edge_sel_type  edge_sel,  // Edge selection
  output logic                            edge_hit   // One-cycle event
);
  import ext_irq_pkg::*;

  logic sync_first;   // First stage, read only by second
  logic sync_second;  // Settled level
  logic sync_prev;    // Previous settled level

  // Two-stage synchroniser then one compare stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
      sync_prev   <= 1'b1;
    end else begin
      sync_first  <= pin;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  // Qualify edge by selection; reserved code gives no event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_hit <= 1'b0;
    end else begin
      edge_hit <= (edge_sel[0] && sync_second && !sync_prev) ||
                  (edge_sel[1] && !sync_second && sync_prev);
    end
  end
endmodule // pin_edge_detect

// ---- rtl/vector_lookup.sv ----
// Registered lookup of the fixed service vector per source
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module vector_lookup (
  input  wire logic                      pclk,     // System clock
  input  wire logic                      presetn,  // Async reset, low
  input  wire ext_irq_pkg::src_vec_type  pending,  // Gated requests
  output logic [15:0]                    vector,   // Chosen vector
  output logic [2:0]                     src_id,   // Chosen source
  output logic                           valid     // Any request
);
  import ext_irq_pkg::*;

  // Fixed priority, lowest source number first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector <= 16'h0000;
      src_id <= 3'h0;
      valid  <= 1'b0;
    end else begin
      valid <= |pending;
      if (pending[0]) begin
        vector <= `VEC_0;
        src_id <= 3'h0;
      end else if (pending[1]) begin
        vector <= `VEC_1;
        src_id <= 3'h1;
      end else if (pending[2]) begin
        vector <= `VEC_2;
        src_id <= 3'h2;
      end else if (pending[3]) begin
        vector <= `VEC_3;
        src_id <= 3'h3;
      end else if (pending[4]) begin
        vector <= `VEC_4;
        src_id <= 3'h4;
      end else begin
        vector <= 16'h0000;
        src_id <= 3'h0;
      end
    end
  end
endmodule // vector_lookup
